// >>> charger_supervisor_pkg.sv
/*
  Package for the charger fault and regulation supervisor: register indices,
  field positions, reset values, codes and timing counts.
  Assumes a 100 MHz mclk and an external two-wire register port that presents
  decoded byte writes and reads at the documented register indices.
*/
// Behaviour
// - Switch peak overcurrent while charging: flag, pulse, stop
// - Battery voltage above threshold engages gate regulation
// - Entering voltage regulation sets flag, one pulse
// - Battery current above threshold reduces gate drive
// - Regulation held 650ms, timeout enabled: stop charging
// - Dropout above threshold past deglitch: stop charging
// - Deglitch length chosen by bit in 0x05
// - Die at 150C stops charging
// - No restart until die falls to 130C
// - Frequency select defaults 500kHz, field in 0x01
// - Host writes regulation thresholds; device compares them
// - Mode 010 starts divider init, 000 disabled
// - Masked event updates flag without interrupt pulse
package charger_supervisor_pkg;

  // Register indices on the two-wire port
  localparam logic [7:0] SWITCHING_CONFIG_ADDR  = 8'h01;
  localparam logic [7:0] PROTECTION_CONFIG_ADDR = 8'h05;
  localparam logic [7:0] CHARGE_CONTROL_ADDR    = 8'h10;
  localparam logic [7:0] EVENT_FLAG_ADDR        = 8'h11;
  localparam logic [7:0] EVENT_MASK_ADDR        = 8'h12;
  localparam logic [7:0] VBAT_THRESHOLD_ADDR    = 8'h13;
  localparam logic [7:0] IBAT_THRESHOLD_ADDR    = 8'h14;
  localparam logic [7:0] STATUS_ADDR            = 8'h15;

  // Field positions
  localparam int FREQ_SEL_LSB      = 0;
  localparam int DROPOUT_DEG_BIT   = 0;
  localparam int REG_TIMEOUT_BIT   = 1;
  localparam int CHARGE_MODE_LSB   = 0;

  // Reset values
  localparam logic [2:0] FREQ_SEL_500KHZ       = 3'h2;
  localparam logic [7:0] SWITCHING_CONFIG_RST  = 8'h02;
  localparam logic [7:0] PROTECTION_CONFIG_RST = 8'h00;
  localparam logic [7:0] THRESHOLD_RST         = 8'hFF;

  // Charge mode codes
  localparam logic [2:0] MODE_DISABLE = 3'h0;
  localparam logic [2:0] MODE_DIVIDER = 3'h2;

  // Event flag bit positions
  localparam int EV_PEAK   = 0;
  localparam int EV_VREG   = 1;
  localparam int EV_IREG   = 2;
  localparam int EV_DROP   = 3;
  localparam int EV_OTP    = 4;
  localparam int EV_TIMEOUT = 5;
  localparam int EVENT_COUNT = 6;

  // Timing
  localparam int CLK_MHZ            = 100;
  localparam int REG_TIMEOUT_MS     = 650;
  localparam int REG_TIMEOUT_CYCLES = REG_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int DEG_SHORT_US       = 10;
  localparam int DEG_LONG_US        = 100;
  localparam int DEG_SHORT_CYCLES   = DEG_SHORT_US * CLK_MHZ;
  localparam int DEG_LONG_CYCLES    = DEG_LONG_US * CLK_MHZ;
  localparam int INT_PULSE_US       = 256;
  localparam int INT_PULSE_CYCLES   = INT_PULSE_US * CLK_MHZ;

  // Synchronised analog condition inputs
  typedef struct packed {
    logic peak_hs;
    logic peak_ls;
    logic dropout;
    logic temp_hot;
    logic temp_cool;
  } condition_type;

endpackage

// >>> interrupt_pulser.sv
/*
  Holds the open-drain interrupt line low for a fixed time after a trigger.
  Assumes triggers come from logic on mclk.
*/
`timescale 1ns/100ps
module interrupt_pulser
  import charger_supervisor_pkg::*;
#(
  parameter int PULSE_CYCLES = INT_PULSE_CYCLES
) (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic trigger,
  output logic      pulse_active
);

  logic [31:0] count;
  logic [31:0] next_count;

  // A new trigger restarts the pulse rather than being dropped
  always_comb begin
    next_count = count;
    if (trigger) begin
      next_count = 32'(PULSE_CYCLES);
    end else if (count != 32'h0) begin
      next_count = count - 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count <= 32'h0;
    end else begin
      count <= next_count;
    end
  end

  assign pulse_active = (count != 32'h0);

endmodule // interrupt_pulser

// >>> charger_supervisor.sv
/*
  Charger supervisor: protection paths, regulation timer, registers.
  Assumes analog comparators on the condition pins, an external two-wire
  serial slave presenting one-cycle byte writes/reads, and a pull-up on the
  interrupt line.
*/
`timescale 1ns/100ps
module charger_supervisor
  import charger_supervisor_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = REG_TIMEOUT_CYCLES,
  parameter int PULSE_CYCLES   = INT_PULSE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       switch_peak_overcurrent_hs,
  input  wire logic       switch_peak_overcurrent_ls,
  input  wire logic       dropout_overvoltage,
  input  wire logic       die_hot,
  input  wire logic       die_cool,
  input  wire logic [7:0] battery_voltage,
  input  wire logic [7:0] battery_current,
  output logic      [7:0] input_fet_gate_drive,
  output logic      [2:0] switching_frequency_select,
  output logic      [2:0] charge_mode_field,
  output logic            interrupt_out_n_out,
  output logic            interrupt_out_n_oe
);

  // Three-stage synchronisers for the comparator pins
  condition_type raw;
  condition_type sync1;
  condition_type sync2;
  condition_type sync3;
  condition_type cond;
  condition_type next_cond;

  assign raw = '{peak_hs: switch_peak_overcurrent_hs, peak_ls: switch_peak_overcurrent_ls,
                 dropout: dropout_overvoltage, temp_hot: die_hot, temp_cool: die_cool};

  // Change accepted only once stages two and three agree
  always_comb begin
    next_cond = cond;
    for (int i = 0; i < $bits(condition_type); i++) begin
      if (sync2[i] == sync3[i]) begin
        next_cond[i] = sync2[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      cond  <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      cond  <= next_cond;
    end
  end

  // Register state
  logic [7:0]             switching_config;
  logic [7:0]             protection_config;
  logic [2:0]             charge_mode;
  logic [EVENT_COUNT-1:0] event_flag;
  logic [EVENT_COUNT-1:0] event_mask;
  logic [7:0]             vbat_threshold;
  logic [7:0]             ibat_threshold;
  logic                   otp_lock;
  logic [7:0]             gate_drive;
  logic                   vreg_prev;
  logic [31:0]            reg_timer;
  logic [31:0]            drop_timer;
  logic [7:0]             next_switching_config;
  logic [7:0]             next_protection_config;
  logic [2:0]             next_charge_mode;
  logic [EVENT_COUNT-1:0] next_event_flag;
  logic [EVENT_COUNT-1:0] next_event_mask;
  logic [7:0]             next_vbat_threshold;
  logic [7:0]             next_ibat_threshold;
  logic                   next_otp_lock;
  logic [7:0]             next_gate_drive;
  logic [31:0]            next_reg_timer;
  logic [31:0]            next_drop_timer;
  logic [7:0]             next_reg_rdata;

  logic                   charging;
  logic                   vreg_active;
  logic                   ireg_active;
  logic                   peak_fault;
  logic                   drop_fault;
  logic                   timeout_fault;
  logic [31:0]            drop_limit;
  logic [EVENT_COUNT-1:0] event_set;
  logic                   int_trigger;
  logic                   pulse_active;

  assign charging    = (charge_mode != MODE_DISABLE);
  assign vreg_active = charging && (battery_voltage > vbat_threshold);
  assign ireg_active = charging && (battery_current > ibat_threshold);
  assign peak_fault  = charging && (cond.peak_hs || cond.peak_ls);
  assign drop_limit  = protection_config[DROPOUT_DEG_BIT] ? 32'(DEG_LONG_CYCLES)
                                                          : 32'(DEG_SHORT_CYCLES);
  assign drop_fault  = charging && cond.dropout && (drop_timer >= drop_limit);
  assign timeout_fault = !protection_config[REG_TIMEOUT_BIT]
                         && (reg_timer >= 32'(TIMEOUT_CYCLES));

  // Event detection; voltage regulation flags only on entry
  always_comb begin
    event_set            = '0;
    event_set[EV_PEAK]   = peak_fault;
    event_set[EV_VREG]   = vreg_active && !vreg_prev;
    event_set[EV_IREG]   = ireg_active && !event_flag[EV_IREG];
    event_set[EV_DROP]   = drop_fault;
    event_set[EV_OTP]    = charging && cond.temp_hot;
    event_set[EV_TIMEOUT] = charging && timeout_fault;
  end

  // Masked events still set their flag but do not pulse
  assign int_trigger = |(event_set & ~event_flag & ~event_mask);

  // Timers: dropout deglitch and regulation persistence.
  // Saturate only while the condition stands, so a stop never leaves a stale count behind
  always_comb begin
    next_drop_timer = 32'h0;
    if (charging && cond.dropout) begin
      next_drop_timer = (drop_timer == 32'hFFFF_FFFF) ? drop_timer : drop_timer + 32'h1;
    end
    // Restart when both regulations go idle before timeout
    next_reg_timer = 32'h0;
    if (vreg_active || ireg_active) begin
      next_reg_timer = (reg_timer >= 32'(TIMEOUT_CYCLES)) ? reg_timer : reg_timer + 32'h1;
    end
  end

  // Gate drive regulation: step down while either regulation is active
  always_comb begin
    next_gate_drive = gate_drive;
    if (!charging) begin
      next_gate_drive = 8'hFF;
    end else if ((vreg_active || ireg_active) && gate_drive != 8'h00) begin
      next_gate_drive = gate_drive - 8'h01;
    end else if (!vreg_active && !ireg_active && gate_drive != 8'hFF) begin
      next_gate_drive = gate_drive + 8'h01;
    end
  end

  // Register writes, charge mode control, flags and lockout
  always_comb begin
    next_switching_config  = switching_config;
    next_protection_config = protection_config;
    next_charge_mode       = charge_mode;
    next_event_mask        = event_mask;
    next_vbat_threshold    = vbat_threshold;
    next_ibat_threshold    = ibat_threshold;
    next_otp_lock          = otp_lock;
    next_event_flag        = event_flag;
    next_reg_rdata         = reg_rdata;
    if (reg_write) begin
      case (reg_addr)
        SWITCHING_CONFIG_ADDR:  next_switching_config  = reg_wdata;
        PROTECTION_CONFIG_ADDR: next_protection_config = reg_wdata;
        EVENT_MASK_ADDR:        next_event_mask        = reg_wdata[EVENT_COUNT-1:0];
        VBAT_THRESHOLD_ADDR:    next_vbat_threshold    = reg_wdata;
        IBAT_THRESHOLD_ADDR:    next_ibat_threshold    = reg_wdata;
        CHARGE_CONTROL_ADDR: begin
          // Startup refused while over-temperature lockout stands
          if (!otp_lock || reg_wdata[2:0] == MODE_DISABLE) begin
            next_charge_mode = reg_wdata[2:0];
          end
        end
        default: ;
      endcase
    end
    // Reading the flag register clears it; new events win
    if (reg_read) begin
      case (reg_addr)
        SWITCHING_CONFIG_ADDR:  next_reg_rdata = switching_config;
        PROTECTION_CONFIG_ADDR: next_reg_rdata = protection_config;
        CHARGE_CONTROL_ADDR:    next_reg_rdata = {5'h00, charge_mode};
        EVENT_FLAG_ADDR: begin
          next_reg_rdata  = {2'h0, event_flag};
          next_event_flag = '0;
        end
        EVENT_MASK_ADDR:        next_reg_rdata = {2'h0, event_mask};
        VBAT_THRESHOLD_ADDR:    next_reg_rdata = vbat_threshold;
        IBAT_THRESHOLD_ADDR:    next_reg_rdata = ibat_threshold;
        STATUS_ADDR:            next_reg_rdata = {4'h0, otp_lock, ireg_active, vreg_active, charging};
        default:                next_reg_rdata = 8'h00;
      endcase
    end
    next_event_flag = next_event_flag | event_set;
    // Lockout sets at hot and releases only when cool
    if (cond.temp_hot) begin
      next_otp_lock = 1'b1;
    end else if (cond.temp_cool) begin
      next_otp_lock = 1'b0;
    end
    // Any fault forces the disable code, overriding a same-cycle write
    if (peak_fault || drop_fault || timeout_fault || cond.temp_hot) begin
      next_charge_mode = MODE_DISABLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      switching_config  <= SWITCHING_CONFIG_RST;
      protection_config <= PROTECTION_CONFIG_RST;
      charge_mode       <= MODE_DISABLE;
      event_flag        <= '0;
      event_mask        <= '0;
      vbat_threshold    <= THRESHOLD_RST;
      ibat_threshold    <= THRESHOLD_RST;
      otp_lock          <= 1'b0;
      gate_drive        <= 8'hFF;
      vreg_prev         <= 1'b0;
      reg_timer         <= 32'h0;
      drop_timer        <= 32'h0;
      reg_rdata         <= 8'h00;
    end else begin
      switching_config  <= next_switching_config;
      protection_config <= next_protection_config;
      charge_mode       <= next_charge_mode;
      event_flag        <= next_event_flag;
      event_mask        <= next_event_mask;
      vbat_threshold    <= next_vbat_threshold;
      ibat_threshold    <= next_ibat_threshold;
      otp_lock          <= next_otp_lock;
      gate_drive        <= next_gate_drive;
      vreg_prev         <= vreg_active;
      reg_timer         <= next_reg_timer;
      drop_timer        <= next_drop_timer;
      reg_rdata         <= next_reg_rdata;
    end
  end

  interrupt_pulser #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pulser (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .trigger      (int_trigger),
    .pulse_active (pulse_active)
  );

  // Open drain: drive low only while pulsing
  assign interrupt_out_n_out        = 1'b0;
  assign interrupt_out_n_oe         = pulse_active;
  assign input_fet_gate_drive       = gate_drive;
  assign switching_frequency_select = switching_config[FREQ_SEL_LSB +: 3];
  assign charge_mode_field          = charge_mode;

  // Assertions
  sequence peak_seen;
    charging && (cond.peak_hs || cond.peak_ls);
  endsequence

  chk_peak_stops_charge: assert property (@(posedge mclk) disable iff (!reset_n)
    peak_seen |=> charge_mode == MODE_DISABLE && event_flag[EV_PEAK])
    else $error("peak overcurrent did not stop charging");

  chk_peak_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    (peak_seen and (!event_flag[EV_PEAK] && !event_mask[EV_PEAK])) |=> interrupt_out_n_oe)
    else $error("peak overcurrent gave no interrupt");

  chk_vreg_gate_falls: assert property (@(posedge mclk) disable iff (!reset_n)
    vreg_active && gate_drive != 8'h00 |=> gate_drive == $past(gate_drive) - 8'h01)
    else $error("gate drive not reduced in voltage regulation");

  chk_vreg_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    vreg_active && !vreg_prev |=> event_flag[EV_VREG])
    else $error("voltage regulation flag not set");

  chk_ireg_gate_falls: assert property (@(posedge mclk) disable iff (!reset_n)
    ireg_active && gate_drive != 8'h00 |=> gate_drive < $past(gate_drive))
    else $error("gate drive not reduced in current regulation");

  chk_timeout_stop: assert property (@(posedge mclk) disable iff (!reset_n)
    timeout_fault |=> charge_mode == MODE_DISABLE)
    else $error("regulation timeout did not stop charging");

  chk_timer_restart: assert property (@(posedge mclk) disable iff (!reset_n)
    !vreg_active && !ireg_active |=> reg_timer == 32'h0)
    else $error("persistence timer not restarted");

  chk_dropout_stop: assert property (@(posedge mclk) disable iff (!reset_n)
    drop_fault |=> charge_mode == MODE_DISABLE)
    else $error("dropout did not stop charging");

  chk_otp_lock: assert property (@(posedge mclk) disable iff (!reset_n)
    otp_lock && !cond.temp_cool |=> charge_mode == MODE_DISABLE)
    else $error("charging started during thermal lockout");

  chk_mask_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    !pulse_active && (event_set & ~event_mask) == '0 |=> !interrupt_out_n_oe)
    else $error("masked event pulsed the interrupt");

  chk_freq_reset: assert property (@(posedge mclk)
    !reset_n |=> switching_frequency_select == FREQ_SEL_500KHZ)
    else $error("frequency select not 500kHz after reset");

endmodule // charger_supervisor

// >>> tb_top.sv
/*
  Self-checking testbench for the charger supervisor: register port,
  peak overcurrent, regulation and its timer, dropout deglitch, thermal lockout.
  Assumes the supervisor package and design files are compiled first, and that
  the assertions live inside the design files.
*/
`timescale 1ns/100ps
module tb_top;
  import charger_supervisor_pkg::*;

  localparam int TMO   = 50;
  localparam int PLS   = 4;
  localparam int LIMIT = 60000;

  logic       mclk;
  logic       reset_n;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       hs;
  logic       ls;
  logic       drop;
  logic       hot;
  logic       cool;
  logic [7:0] vbat;
  logic [7:0] ibat;
  logic [7:0] gate;
  logic [2:0] fsel;
  logic [2:0] mode;
  logic       int_out;
  logic       int_oe;
  int         n_mismatch;
  int         tests_run;
  int         cyc;
  int         oe_cycles;

  // Short timer and pulse so the regulation timeout fits in the run
  charger_supervisor #(.TIMEOUT_CYCLES(TMO), .PULSE_CYCLES(PLS)) charger_supervisor_inst (
    .mclk                       (mclk),
    .reset_n                    (reset_n),
    .reg_write                  (reg_write),
    .reg_read                   (reg_read),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_rdata                  (reg_rdata),
    .switch_peak_overcurrent_hs (hs),
    .switch_peak_overcurrent_ls (ls),
    .dropout_overvoltage        (drop),
    .die_hot                    (hot),
    .die_cool                   (cool),
    .battery_voltage            (vbat),
    .battery_current            (ibat),
    .input_fet_gate_drive       (gate),
    .switching_frequency_select (fsel),
    .charge_mode_field          (mode),
    .interrupt_out_n_out        (int_out),
    .interrupt_out_n_oe         (int_oe)
  );

  // Free-running 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cycle count for the hang limit, and interrupt low-time accumulator
  always @(posedge mclk) begin
    cyc++;
    if (int_oe === 1'b1) oe_cycles++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Fresh start for each scenario; the die starts cool and conditions idle
  task automatic reset_dut();
    @(negedge mclk);
    reset_n = 1'b0;
    {hs, ls, drop, hot} = 4'h0;
    cool = 1'b1;
    vbat = 8'h00;
    ibat = 8'h00;
    idle(2);
    reset_n = 1'b1;
    oe_cycles = 0;
  endtask

  // One-cycle write strobe, taken on the rising edge in between; a quiet edge
  // follows so a back-to-back call never re-raises the strobe in the same step
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_write = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge mclk);
    reg_write = 1'b0;
    @(negedge mclk);
  endtask

  // Read data is registered, so it is settled by the following falling edge
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    reg_read = 1'b1;
    reg_addr = addr;
    @(negedge mclk);
    reg_read = 1'b0;
    data = reg_rdata;
    @(negedge mclk);
  endtask

  // Bounded wait for a charge mode value, then judged
  task automatic wait_mode(input logic [2:0] exp, input int maxc);
    for (int i = 0; i < maxc && mode !== exp; i++) @(negedge mclk);
    check({5'h00, mode}, {5'h00, exp});
  endtask

  task automatic t_reset();
    logic [7:0] d;
    reset_dut();
    rd(8'h01, d);
    check(d, 8'h02);
    check({5'h00, fsel}, 8'h02);
    rd(8'h05, d);
    check(d, 8'h00);
    check({5'h00, mode}, 8'h00);
    check(gate, 8'hFF);
    wr(8'h7F, 8'hA5);
    rd(8'h7F, d);
    check(d, 8'h00);
    wr(8'h01, 8'h05);
    idle(1);
    check({5'h00, fsel}, 8'h05);
  endtask

  // Peak overcurrent on either switch, with and without the event masked
  task automatic t_peak(input logic lowside, input logic masked);
    logic [7:0] d;
    reset_dut();
    if (masked) wr(8'h12, 8'h01);
    wr(8'h10, 8'h02);
    check({5'h00, mode}, 8'h02);
    oe_cycles = 0;
    hs = ~lowside;
    ls = lowside;
    wait_mode(3'h0, 20);
    check({7'h00, int_oe}, masked ? 8'h00 : 8'h01);
    check({7'h00, int_out}, 8'h00);
    idle(PLS + 4);
    check(8'(oe_cycles), masked ? 8'h00 : 8'(PLS));
    rd(8'h11, d);
    check(d & 8'h01, 8'h01);
    hs = 1'b0;
    ls = 1'b0;
  endtask

  // Voltage regulation: boundary, gate control, entry event, timeout
  task automatic t_vreg();
    logic [7:0] d;
    reset_dut();
    wr(8'h13, 8'h80);
    wr(8'h10, 8'h02);
    vbat = 8'h80;
    idle(4);
    check(gate, 8'hFF);
    oe_cycles = 0;
    vbat = 8'h90;
    idle(5);
    check({7'h00, gate < 8'hFF}, 8'h01);
    idle(PLS + 2);
    check(8'(oe_cycles), 8'(PLS));
    rd(8'h11, d);
    check(d & 8'h02, 8'h02);
    idle(TMO - 30);
    check({5'h00, mode}, 8'h02);
    wait_mode(3'h0, 40);
    vbat = 8'h00;
  endtask

  // Current regulation, timer restart on a gap, and timeout disabled
  task automatic t_ireg();
    reset_dut();
    wr(8'h14, 8'h40);
    wr(8'h10, 8'h02);
    ibat = 8'h41;
    idle(5);
    check({7'h00, gate < 8'hFF}, 8'h01);
    idle(25);
    ibat = 8'h00;
    idle(5);
    ibat = 8'h41;
    idle(35);
    check({5'h00, mode}, 8'h02);
    wait_mode(3'h0, 40);
    reset_dut();
    wr(8'h05, 8'h02);
    wr(8'h14, 8'h40);
    wr(8'h10, 8'h02);
    ibat = 8'h41;
    idle(3 * TMO);
    check({5'h00, mode}, 8'h02);
    ibat = 8'h00;
  endtask

  // Dropout with short or long deglitch; a glitch shorter than it is ignored
  task automatic t_drop(input logic sel);
    reset_dut();
    wr(8'h05, {7'h00, sel});
    wr(8'h10, 8'h02);
    drop = 1'b1;
    idle(sel ? 5000 : 500);
    drop = 1'b0;
    idle(5);
    check({5'h00, mode}, 8'h02);
    drop = 1'b1;
    idle(sel ? 9500 : 950);
    check({5'h00, mode}, 8'h02);
    wait_mode(3'h0, 1100);
    drop = 1'b0;
  endtask

  // Over-temperature stop, then lockout until the die is cool again
  task automatic t_otp();
    reset_dut();
    wr(8'h10, 8'h02);
    hot = 1'b1;
    cool = 1'b0;
    wait_mode(3'h0, 20);
    hot = 1'b0;
    idle(10);
    wr(8'h10, 8'h02);
    idle(2);
    check({5'h00, mode}, 8'h00);
    cool = 1'b1;
    idle(10);
    wr(8'h10, 8'h02);
    idle(1);
    check({5'h00, mode}, 8'h02);
  endtask

  // Inputs valued at time zero, then the scenarios in turn
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    oe_cycles = 0;
    reset_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {hs, ls, drop, hot} = 4'h0;
    cool = 1'b1;
    vbat = 8'h00;
    ibat = 8'h00;
    t_reset();
    t_peak(1'b0, 1'b0);
    t_peak(1'b1, 1'b0);
    t_peak(1'b0, 1'b1);
    t_vreg();
    t_ireg();
    t_drop(1'b0);
    t_drop(1'b1);
    t_otp();
    summarize();
  end
endmodule // tb_top
